// ===== common/ocr_pkg.sv
/*
 Constants, register layout and state encoding for the overcurrent fault response block.
 Assumes a PMBus command decoder outside that presents byte writes and reads per page.
*/
package ocr_pkg;
    localparam int         NUM_CH         = 2;
    localparam logic [7:0] CMD_OC_ACTION  = 8'h47;
    localparam logic [7:0] CMD_OT_ACTION  = 8'hd6;
    localparam logic [7:0] OC_ACTION_RST  = 8'h00;
    localparam logic [7:0] OT_ACTION_VAL  = 8'hc0;
    localparam int         RESP_MSB       = 7;
    localparam int         RESP_LSB       = 6;
    localparam int         RETRY_MSB      = 5;
    localparam int         RETRY_LSB      = 3;
    localparam int         DELAY_MSB      = 2;
    localparam int         DELAY_LSB      = 0;
    localparam logic [1:0] RESP_CONT      = 2'h0;
    localparam logic [1:0] RESP_UNSUP     = 2'h1;
    localparam logic [1:0] RESP_DELAYED   = 2'h2;
    localparam logic [1:0] RESP_SHUT      = 2'h3;
    localparam logic [2:0] RETRY_FOREVER  = 3'h7;
    localparam int         DELAY_UNIT_MS  = 16;
    localparam int         TICK_MS        = 1;
    localparam int         CLK_HZ         = 100_000_000;
    localparam int         MS_CYCLES      = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [2:0] {
        ST_RUN   = 3'h0,
        ST_LIMIT = 3'h1,
        ST_SHUT  = 3'h3,
        ST_WAIT  = 3'h2,
        ST_OFF   = 3'h4
    } ocr_state_t;

    typedef struct packed {
        logic [23:0]                    pre;
        logic [NUM_CH-1:0][7:0]         action;
        ocr_state_t [NUM_CH-1:0]        st;
        logic [NUM_CH-1:0][7:0]         cnt;
        logic [NUM_CH-1:0]              was_on;
        logic [NUM_CH-1:0]              no_retry;
        logic [NUM_CH-1:0]              flag;
        logic [NUM_CH-1:0]              oen;
        logic [NUM_CH-1:0]              ilim;
        logic [NUM_CH-1:0]              uv_mask;
        logic                           alert;
        logic [7:0]                     rd_data;
        logic                           rd_valid;
        logic                           cml_err;
    } ocr_regs_t;
endpackage

// ===== design/ocr_fault_resp.sv
/*
 Overcurrent fault response logic for both output channels, with the response byte
 store and the fixed internal overtemperature action byte.
 Assumes command strobes, fault detect levels and run control levels are synchronous
 to clk_sys_in; bias power loss is seen as resetn_in.
*/
`timescale 1ns/10ps
module ocr_fault_resp #(
    parameter int MS_CYCLES_P = ocr_pkg::MS_CYCLES
) (
    input  wire logic                      clk_sys_in,              // System clock, 100 MHz.
    input  wire logic                      resetn_in,               // Bias power reset, low.
    input  wire logic                      cmd_wr_in,               // Command byte write strobe.
    input  wire logic                      cmd_rd_in,               // Command byte read strobe.
    input  wire logic [7:0]                cmd_code_in,             // Command code.
    input  wire logic                      cmd_page_in,             // Selected page (channel).
    input  wire logic [7:0]                cmd_wdata_in,            // Write data byte.
    input  wire logic                      clear_faults_in,         // Clear faults pulse.
    input  wire logic [ocr_pkg::NUM_CH-1:0] run_control_pin_in,     // Run control level.
    input  wire logic [ocr_pkg::NUM_CH-1:0] operation_on_in,        // Operation command on.
    input  wire logic [ocr_pkg::NUM_CH-1:0] oc_detect_in,           // In current limit.
    input  wire logic [ocr_pkg::NUM_CH-1:0] other_fault_in,         // Shutdown, no retry.
    input  wire logic [7:0]                restart_interval_setting_in, // Retry gap, ms.
    output logic [7:0]                     rd_data_out,             // Read data byte.
    output logic                           rd_valid_out,            // Read data valid pulse.
    output logic                           cml_err_out,             // Communication error pulse.
    output logic [ocr_pkg::NUM_CH-1:0]     output_enable_out,       // Channel output enabled.
    output logic [ocr_pkg::NUM_CH-1:0]     current_limit_out,       // Hold current at limit.
    output logic [ocr_pkg::NUM_CH-1:0]     uv_mask_out,             // Mask UV detection.
    output logic [ocr_pkg::NUM_CH-1:0]     status_byte_oc_out,      // Status byte OC bit.
    output logic [ocr_pkg::NUM_CH-1:0]     status_word_iout_out,    // Status word IOUT bit.
    output logic [ocr_pkg::NUM_CH-1:0]     status_iout_oc_out,      // Output current OC bit.
    output logic                           alert_out,               // Alert pin level driven.
    output logic                           alert_oe_out             // Alert pin pulled low.
);
    import ocr_pkg::*;

    localparam logic [23:0] PRE_LAST = 24'(MS_CYCLES_P - 1);

    ocr_regs_t r;
    ocr_regs_t next_r;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Counts down one step on a millisecond tick, holding at zero.
    function automatic logic [7:0] count_down(input logic [7:0] c, input logic t);
        count_down = (t && c != 8'h00) ? c - 8'h01 : c;
    endfunction

    function automatic logic ch_active(input ocr_state_t s);
        ch_active = (s == ST_RUN) || (s == ST_LIMIT);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb begin
        logic       tick;
        logic       on;
        logic       clr;
        logic       oc;
        logic [7:0] act;
        tick = 1'b0;
        on   = 1'b0;
        clr  = 1'b0;
        oc   = 1'b0;
        act  = 8'h00;

        next_r          = r;
        next_r.rd_valid = 1'b0;
        next_r.cml_err  = 1'b0;

        tick       = (r.pre == PRE_LAST);
        next_r.pre = tick ? 24'h000000 : r.pre + 24'h000001;

        if (cmd_wr_in) begin
            if (cmd_code_in == CMD_OC_ACTION) begin
                next_r.action[cmd_page_in] = cmd_wdata_in;
                if (cmd_wdata_in[RESP_MSB:RESP_LSB] == RESP_UNSUP) begin
                    next_r.cml_err = 1'b1;
                end
            end else if (cmd_code_in == CMD_OT_ACTION) begin
                next_r.cml_err = 1'b1;
            end
        end

        if (cmd_rd_in) begin
            next_r.rd_valid = 1'b1;
            if (cmd_code_in == CMD_OC_ACTION) begin
                next_r.rd_data = r.action[cmd_page_in];
            end else if (cmd_code_in == CMD_OT_ACTION) begin
                next_r.rd_data = OT_ACTION_VAL;
            end else begin
                next_r.rd_data = 8'h00;
            end
        end

        for (int ch = 0; ch < NUM_CH; ch++) begin
            on  = run_control_pin_in[ch] & operation_on_in[ch];
            clr = clear_faults_in | (on & ~r.was_on[ch]);
            oc  = oc_detect_in[ch];
            act = r.action[ch];
            next_r.was_on[ch] = on;

            case (r.st[ch])
                ST_OFF: begin
                    if (on) begin
                        next_r.st[ch]       = ST_RUN;
                        next_r.no_retry[ch] = 1'b0;
                    end
                end
                ST_RUN: begin
                    if (oc) begin
                        case (act[RESP_MSB:RESP_LSB])
                            RESP_DELAYED: begin
                                if (act[DELAY_MSB:DELAY_LSB] == 3'h0) begin
                                    next_r.st[ch] = ST_SHUT;
                                end else begin
                                    next_r.st[ch]  = ST_LIMIT;
                                    next_r.cnt[ch] = 8'(act[DELAY_MSB:DELAY_LSB]
                                                     * DELAY_UNIT_MS);
                                end
                            end
                            RESP_SHUT: begin
                                next_r.st[ch] = ST_SHUT;
                            end
                            default: begin
                                next_r.st[ch] = ST_RUN;
                            end
                        endcase
                    end
                end
                ST_LIMIT: begin
                    if (!oc) begin
                        next_r.st[ch] = ST_RUN;
                    end else if (tick && r.cnt[ch] == 8'h01) begin
                        next_r.st[ch] = ST_SHUT;
                    end else begin
                        next_r.cnt[ch] = count_down(r.cnt[ch], tick);
                    end
                end
                ST_SHUT: begin
                    if (act[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER && !r.no_retry[ch]) begin
                        next_r.st[ch]  = ST_WAIT;
                        next_r.cnt[ch] = restart_interval_setting_in;
                    end
                end
                ST_WAIT: begin
                    if (r.cnt[ch] == 8'h00) begin
                        next_r.st[ch] = ST_RUN;
                    end else begin
                        next_r.cnt[ch] = count_down(r.cnt[ch], tick);
                    end
                end
                default: begin
                    next_r.st[ch] = ST_OFF;
                end
            endcase

            if (other_fault_in[ch] && r.st[ch] != ST_OFF) begin
                next_r.st[ch]       = ST_SHUT;
                next_r.no_retry[ch] = 1'b1;
            end
            if (!on) begin
                next_r.st[ch] = ST_OFF;
            end

            // Set wins over clear so a fault in the clearing cycle is kept.
            next_r.flag[ch] = (oc & ch_active(r.st[ch])) | (r.flag[ch] & ~clr);
            next_r.oen[ch]     = ch_active(next_r.st[ch]);
            next_r.ilim[ch]    = oc & ch_active(next_r.st[ch]);
            next_r.uv_mask[ch] = oc;
        end

        next_r.alert = |next_r.flag;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r          <= '0;
            r.action   <= {NUM_CH{OC_ACTION_RST}};
            r.st       <= '{default: ST_OFF};
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign rd_data_out          = r.rd_data;
    assign rd_valid_out         = r.rd_valid;
    assign cml_err_out          = r.cml_err;
    assign output_enable_out    = r.oen;
    assign current_limit_out    = r.ilim;
    assign uv_mask_out          = r.uv_mask;
    assign status_byte_oc_out   = r.flag;
    assign status_word_iout_out = r.flag;
    assign status_iout_oc_out   = r.flag;
    assign alert_out            = 1'b0;
    assign alert_oe_out         = r.alert;

endmodule // ocr_fault_resp

// ===== tb/ocr_fault_resp_asserts.sv
/*
 Concurrent checks on the overcurrent response block, channel 0 and command bus.
 Assumes it is bound to ocr_fault_resp and sees only its ports.
*/
`timescale 1ns/10ps
module ocr_fault_resp_asserts #(
    parameter int MS_CYCLES_P = 10
) (
    input wire logic                       clk_sys_in,           // System clock.
    input wire logic                       resetn_in,            // Bias power reset, low.
    input wire logic                       cmd_wr_in,            // Write strobe.
    input wire logic                       cmd_rd_in,            // Read strobe.
    input wire logic [7:0]                 cmd_code_in,          // Command code.
    input wire logic [7:0]                 cmd_wdata_in,         // Write data byte.
    input wire logic                       clear_faults_in,      // Clear faults pulse.
    input wire logic [ocr_pkg::NUM_CH-1:0] run_control_pin_in,   // Run control level.
    input wire logic [ocr_pkg::NUM_CH-1:0] operation_on_in,      // Operation command on.
    input wire logic [ocr_pkg::NUM_CH-1:0] oc_detect_in,         // In current limit.
    input wire logic [7:0]                 rd_data_out,          // Read data byte.
    input wire logic                       rd_valid_out,         // Read data valid.
    input wire logic                       cml_err_out,          // Communication error.
    input wire logic [ocr_pkg::NUM_CH-1:0] output_enable_out,    // Output enabled.
    input wire logic [ocr_pkg::NUM_CH-1:0] uv_mask_out,          // Undervoltage mask.
    input wire logic [ocr_pkg::NUM_CH-1:0] status_byte_oc_out,   // Status byte copy.
    input wire logic [ocr_pkg::NUM_CH-1:0] status_word_iout_out, // Status word copy.
    input wire logic [ocr_pkg::NUM_CH-1:0] status_iout_oc_out,   // Output current copy.
    input wire logic                       alert_out,            // Alert pin value.
    input wire logic                       alert_oe_out          // Alert pin pulled low.
);
    logic on0;
    assign on0 = run_control_pin_in[0] & operation_on_in[0];
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    flag_set_a: assert property (output_enable_out[0] && oc_detect_in[0] |=> status_byte_oc_out[0])
        else $error("overcurrent flag not set");
    status_same_a: assert property (status_word_iout_out == status_byte_oc_out
        && status_iout_oc_out == status_byte_oc_out) else $error("status copies differ");
    alert_or_a: assert property (alert_oe_out == (|status_byte_oc_out) && !alert_out)
        else $error("alert does not follow flags");
    flag_hold_a: assert property (status_byte_oc_out[0] && !clear_faults_in
        && !(on0 && !$past(on0)) |=> status_byte_oc_out[0]) else $error("flag lost");
    off_drop_a: assert property (!on0 |=> !output_enable_out[0])
        else $error("output stays on while commanded off");
    uv_mask_a: assert property (oc_detect_in[0] [*2] |-> uv_mask_out[0])
        else $error("undervoltage not masked");
    rd_answer_a: assert property (cmd_rd_in |=> rd_valid_out) else $error("no read answer");
    ot_read_a: assert property (cmd_rd_in && cmd_code_in == 8'hd6 |=> rd_data_out == 8'hc0)
        else $error("overtemp action byte wrong");
    ot_write_a: assert property (cmd_wr_in && cmd_code_in == 8'hd6 |=> cml_err_out)
        else $error("overtemp write not refused");
    unsup_resp_a: assert property (cmd_wr_in && cmd_code_in == 8'h47
        && cmd_wdata_in[7:6] == 2'h1 |=> cml_err_out) else $error("response 01 not flagged");
    cover property ($fell(output_enable_out[0]));
    cover property ($rose(alert_oe_out));
    cover property (cml_err_out);
endmodule // ocr_fault_resp_asserts

bind ocr_fault_resp ocr_fault_resp_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) u_ocr_fault_resp_asserts (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cmd_wr_in(cmd_wr_in),
    .cmd_rd_in(cmd_rd_in), .cmd_code_in(cmd_code_in), .cmd_wdata_in(cmd_wdata_in),
    .clear_faults_in(clear_faults_in), .run_control_pin_in(run_control_pin_in),
    .operation_on_in(operation_on_in), .oc_detect_in(oc_detect_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .cml_err_out(cml_err_out),
    .output_enable_out(output_enable_out), .uv_mask_out(uv_mask_out),
    .status_byte_oc_out(status_byte_oc_out), .status_word_iout_out(status_word_iout_out),
    .status_iout_oc_out(status_iout_oc_out), .alert_out(alert_out),
    .alert_oe_out(alert_oe_out));

// ===== tb/ocr_host_model.sv
/*
 Host side model: pulled-up alert wire and capture of answered read bytes.
 Assumes read data and its valid pulse arrive together on the system clock.
*/
`timescale 1ns/10ps
module ocr_host_model (
    input  wire logic       clk_sys_in,  // System clock.
    input  wire logic       alert_oe_in, // Device pulls alert low.
    input  wire logic       rd_valid_in, // Read answer valid.
    input  wire logic [7:0] rd_data_in,  // Read answer byte.
    output logic            alert_n_out, // Resolved alert wire, low active.
    output logic [7:0]      last_rd_out  // Last byte read.
);
    // The pull-up holds the wire high whenever no one pulls it down.
    assign alert_n_out = !alert_oe_in;
    always_ff @(posedge clk_sys_in) begin
        if (rd_valid_in) begin
            last_rd_out <= rd_data_in;
        end
    end
endmodule // ocr_host_model

// ===== tb/ocr_fault_resp_tb_top.sv
/*
 Self-checking bench for the overcurrent response block, channel 0 mostly.
 Assumes the host model resolves the alert wire; a 1 ms tick is 10 cycles here.
*/
`timescale 1ns/10ps
module ocr_fault_resp_tb_top;
    import ocr_pkg::*;
    logic       clk_sys_in, resetn_in, cmd_wr, cmd_rd, page, clr, rdv, cml, aoe, alert_n;
    logic [7:0] code, wdata, rdd, last_rd, gap;
    logic [1:0] run, op, oc, other, en, ilim;
    logic [1:0] sb;
    int         fails, tests_run;

    ocr_fault_resp #(.MS_CYCLES_P(10)) u_ocr_fault_resp (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd),
        .cmd_code_in(code), .cmd_page_in(page), .cmd_wdata_in(wdata), .clear_faults_in(clr),
        .run_control_pin_in(run), .operation_on_in(op), .oc_detect_in(oc),
        .other_fault_in(other), .restart_interval_setting_in(gap), .rd_data_out(rdd),
        .rd_valid_out(rdv), .cml_err_out(cml), .output_enable_out(en),
        .current_limit_out(ilim), .uv_mask_out(), .status_byte_oc_out(sb),
        .status_word_iout_out(), .status_iout_oc_out(), .alert_out(), .alert_oe_out(aoe));
    ocr_host_model u_ocr_host_model (.clk_sys_in(clk_sys_in), .alert_oe_in(aoe),
        .rd_valid_in(rdv), .rd_data_in(rdd), .alert_n_out(alert_n), .last_rd_out(last_rd));

    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Channel 0 view: enable, limit, flag, alert wire.
    function automatic logic [7:0] snap();
        return {4'h0, en[0], ilim[0], sb[0], alert_n};
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr(logic [7:0] c, logic p, logic [7:0] d, logic e);
        @(posedge clk_sys_in);
        {cmd_wr, code, page, wdata} <= {1'b1, c, p, d};
        @(posedge clk_sys_in);
        cmd_wr <= 1'b0;
        #1 chk({7'h0, cml}, {7'h0, e});
    endtask
    task automatic rd(logic [7:0] c, logic p, logic [7:0] e);
        @(posedge clk_sys_in);
        {cmd_rd, code, page} <= {1'b1, c, p};
        @(posedge clk_sys_in);
        cmd_rd <= 1'b0;
        cyc(1);
        chk(last_rd, e);
    endtask
    task automatic set_oc(logic v);
        @(posedge clk_sys_in);
        oc[0] <= v;
    endtask
    task automatic restart();
        @(posedge clk_sys_in);
        run[0] <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        run[0] <= 1'b1;
        cyc(3);
    endtask
    task automatic t_regs();
        rd(8'h47, 1'b0, 8'h00);
        wr(8'h47, 1'b0, 8'h9a, 1'b0);
        rd(8'h47, 1'b0, 8'h9a);
        rd(8'h47, 1'b1, 8'h00);
        wr(8'hd6, 1'b0, 8'h00, 1'b1);
        rd(8'hd6, 1'b1, 8'hc0);
        wr(8'h47, 1'b1, 8'h40, 1'b1);
        $display("regs done");
    endtask
    task automatic t_cont();
        wr(8'h47, 1'b0, 8'h07, 1'b0);
        set_oc(1'b1);
        cyc(1200);
        chk(snap(), 8'h0e);
        chk({6'h00, en[1], sb[1]}, 8'h02);
        set_oc(1'b0);
        cyc(3);
        chk(snap(), 8'h0a);
        @(posedge clk_sys_in);
        clr <= 1'b1;
        @(posedge clk_sys_in);
        clr <= 1'b0;
        cyc(2);
        chk(snap(), 8'h09);
        $display("constant limit done");
    endtask
    task automatic t_shut();
        wr(8'h47, 1'b0, 8'hf0, 1'b0);
        set_oc(1'b1);
        cyc(1);
        chk(snap(), 8'h02);
        set_oc(1'b0);
        cyc(300);
        chk(snap(), 8'h02);
        restart();
        chk(snap(), 8'h09);
        $display("shutdown done");
    endtask
    task automatic t_delay();
        wr(8'h47, 1'b0, 8'h81, 1'b0);
        set_oc(1'b1);
        cyc(140);
        chk(snap(), 8'h0e);
        cyc(25);
        chk(snap(), 8'h02);
        set_oc(1'b0);
        restart();
        set_oc(1'b1);
        cyc(50);
        set_oc(1'b0);
        cyc(200);
        chk(snap(), 8'h0a);
        restart();
        wr(8'h47, 1'b0, 8'h80, 1'b0);
        set_oc(1'b1);
        cyc(1);
        chk(snap(), 8'h02);
        set_oc(1'b0);
        restart();
        $display("delayed shutdown done");
    endtask
    task automatic t_retry();
        wr(8'h47, 1'b0, 8'hff, 1'b0);
        set_oc(1'b1);
        cyc(1);
        set_oc(1'b0);
        cyc(30);
        chk(snap(), 8'h02);
        cyc(40);
        chk(snap(), 8'h0a);
        @(posedge clk_sys_in);
        other[0] <= 1'b1;
        @(posedge clk_sys_in);
        other[0] <= 1'b0;
        cyc(100);
        chk(snap(), 8'h02);
        @(posedge clk_sys_in);
        op[0] <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        op[0] <= 1'b1;
        cyc(3);
        chk(snap(), 8'h09);
        $display("retry done");
    endtask
    task automatic stop_test();
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #200000;
        fails++;
        stop_test();
    end
    initial begin
        {resetn_in, cmd_wr, cmd_rd, page, clr, code, wdata} = '0;
        {run, op, oc, other, gap, fails, tests_run} = {4'hf, 4'h0, 8'h05, 64'h0};
        repeat (16) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        cyc(3);
        t_regs();
        t_cont();
        t_shut();
        t_delay();
        t_retry();
        stop_test();
    end
endmodule // ocr_fault_resp_tb_top
